// [acc_ctrl.v]
// adc and dac conversion control: coding, correction, modes, sequencer triggering
// assumes apb master on MCLK, converter handshake pins synchronous to MCLK
//
// Contract
// - adc results are 16-bit two's complement
// - unipolar dac words are straight binary
// - bipolar dac words are two's complement
// - corrected = data*(1-gain/262144) - offset/4
// - signed 16-bit corrections, zero means unchanged
// - mode selects manual or sequencer per converter
// - manual converts only on software command
// - immediate dac write updates, busy until done
// - controlled dac updates on global request bit
// - one request write updates all requesting dacs
// - sequencer converters convert at same instants
// - sequencer event hits every assigned converter
// - sequencers push adc data, pull dac data
// - per-sequencer normal or frame mode
// - normal mode runs count conversions, zero endless
// - start bit held until clock accepts it
// - normal: first fall after first rise
// - frame trigger starts burst of own count
// - trigger generator period and total limit
// - clocks run only when enabled, or external
// - frame: first fall after trigger converts
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "acc_consts.vh"
module acc_ctrl (
    // clock and reset
    input wire MCLK,
    input wire RST_N,
    // apb slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    // adc converters
    output reg [1:0] ADC_CONVST,
    input wire ADC_RES_VALID,
    input wire [3:0] ADC_RES_CH,
    input wire [15:0] ADC_RES_DATA,
    // dac converters
    output reg DAC_WR,
    output reg [2:0] DAC_ADDR,
    output reg [15:0] DAC_DATA,
    output reg [1:0] DAC_LOAD,
    input wire [1:0] DAC_DONE,
    // sequencer data path
    output reg SEQ_ADC_VALID,
    output reg [15:0] SEQ_ADC_DATA,
    output reg SEQ_DAC_PULL,
    // external conversion signals
    input wire [1:0] EXT_CCLK,
    input wire EXT_FTRIG
);
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_ARM = 2'd1;
    localparam [1:0] ST_RUN = 2'd2;
    localparam [1:0] ST_FWAIT = 2'd3;

    reg [23:0] mode_reg;
    reg [15:0] div_reg [0:1];
    reg [15:0] seq_num_reg [0:1];
    reg [15:0] dac_data_reg [0:7];
    reg [15:0] adc_data_reg [0:15];
    reg [31:0] corr_reg [0:23];
    reg [15:0] ft_per_reg, ft_lim_reg, ft_cnt_reg, ft_done_reg;
    reg ft_csel_reg, gen_en_reg, src_ext_reg, ft_prev_reg, rd_err;
    reg [1:0] seq_frame_reg, seq_csel_reg, busy_reg, load_reg, cc_prev_reg, load_set;
    reg [7:0] pend_reg, pend_set, pend_next;
    reg [31:0] rd_data;
    reg [2:0] pick;
    integer i, j, m;

    wire apb_fire = PSEL & PENABLE & PREADY;
    wire apb_wr = apb_fire & PWRITE;
    wire [1:0] adc_seq = mode_reg[`ACC_MODE_ASEQ+1:`ACC_MODE_ASEQ];
    wire [1:0] dac_seq = mode_reg[`ACC_MODE_DSEQ+1:`ACC_MODE_DSEQ];
    wire [1:0] dac_ctl = mode_reg[`ACC_MODE_DCTL+1:`ACC_MODE_DCTL];
    wire [1:0] dac_bip = mode_reg[`ACC_MODE_DBIP+1:`ACC_MODE_DBIP];
    wire [1:0] adc_cor = mode_reg[`ACC_MODE_ACOR+1:`ACC_MODE_ACOR];
    wire [1:0] dac_cor = mode_reg[`ACC_MODE_DCOR+1:`ACC_MODE_DCOR];
    wire gc_wr = apb_wr && (PADDR == `ACC_OFF_GCTRL);
    wire [1:0] adc_req = gc_wr ? PWDATA[`ACC_GC_AREQ+1:`ACC_GC_AREQ] : 2'b00;
    wire [1:0] dac_req = gc_wr ? PWDATA[`ACC_GC_DREQ+1:`ACC_GC_DREQ] : 2'b00;
    wire dd_wr = apb_wr && (PADDR[11:5] == `ACC_BASE_DDATA >> 5);
    wire [2:0] dd_idx = PADDR[4:2];
    wire [1:0] lvl;
    wire [1:0] cc = src_ext_reg ? EXT_CCLK : lvl;
    wire [1:0] c_rise = cc & ~cc_prev_reg;
    wire [1:0] c_fall = ~cc & cc_prev_reg;
    wire [1:0] seq_ev;
    wire [1:0] seq_start;
    wire [1:0] seq_stop;
    wire ft_int;
    wire ftrig = src_ext_reg ? (EXT_FTRIG & ~ft_prev_reg) : ft_int;

    // gain then offset correction with clamping
    function [15:0] corr_fn;
        input [15:0] d;
        input [31:0] c;
        input bip;
        reg signed [17:0] dx;
        reg signed [17:0] gx;
        reg signed [35:0] p;
        reg signed [19:0] r;
        begin
            dx = bip ? {{2{d[15]}}, d} : {2'b00, d};
            gx = {{2{c[31]}}, c[31:16]};
            p = dx * gx;
            r = {{2{dx[17]}}, dx} - {{2{p[35]}}, p[35:`ACC_GAIN_SHIFT]}
                - {{6{c[15]}}, c[15:`ACC_OFF_SHIFT]};
            corr_fn = r[15:0];
            if (bip && r > 20'sd32767)
                corr_fn = `ACC_POS_FS;
            else if (bip && r < -20'sd32768)
                corr_fn = `ACC_NEG_FS;
            else if (!bip && r < 20'sd0)
                corr_fn = `ACC_UNI_ZERO;
            else if (!bip && r > 20'sd65535)
                corr_fn = `ACC_UNI_TOP;
        end
    endfunction

    // conversion clock dividers
    genvar k;
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_clk
            reg [15:0] cnt_reg;
            reg lvl_reg;
            assign lvl[k] = lvl_reg;
            always @(posedge MCLK) begin
                if (!RST_N || !gen_en_reg) begin
                    cnt_reg <= 16'h0000;
                    lvl_reg <= 1'b0;
                end else if (cnt_reg == div_reg[k]) begin
                    cnt_reg <= 16'h0000;
                    lvl_reg <= ~lvl_reg;
                end else begin
                    cnt_reg <= cnt_reg + 16'h0001;
                end
            end
        end
    endgenerate

    // frame trigger generator
    wire ft_tick = c_rise[ft_csel_reg] & gen_en_reg & ~src_ext_reg;
    wire ft_room = (ft_lim_reg == 16'h0000) || (ft_done_reg < ft_lim_reg);
    wire ft_hit = (ft_cnt_reg + 16'h0001 >= ft_per_reg);
    assign ft_int = ft_tick & ft_room & ft_hit;
    always @(posedge MCLK) begin
        if (!RST_N) begin
            cc_prev_reg <= 2'b00;
            ft_prev_reg <= 1'b0;
            ft_cnt_reg <= 16'h0000;
            ft_done_reg <= 16'h0000;
        end else begin
            cc_prev_reg <= cc;
            ft_prev_reg <= EXT_FTRIG;
            if (!gen_en_reg) begin
                ft_cnt_reg <= 16'h0000;
                ft_done_reg <= 16'h0000;
            end else if (ft_tick && ft_room) begin
                ft_cnt_reg <= ft_hit ? 16'h0000 : ft_cnt_reg + 16'h0001;
                if (ft_hit)
                    ft_done_reg <= ft_done_reg + 16'h0001;
            end
        end
    end

    // sequencers: 0 adc, 1 dac
    genvar s;
    generate
        for (s = 0; s < 2; s = s + 1) begin : g_seq
            reg [1:0] st_reg;
            reg start_reg;
            reg [15:0] n_reg;
            wire f = c_fall[seq_csel_reg[s]];
            wire r = c_rise[seq_csel_reg[s]];
            wire last = (seq_num_reg[s] != 16'h0000) &&
                (n_reg + 16'h0001 == seq_num_reg[s]);
            assign seq_ev[s] = (st_reg == ST_RUN) && f;
            always @(posedge MCLK) begin
                if (!RST_N || seq_stop[s]) begin
                    st_reg <= ST_IDLE;
                    start_reg <= 1'b0;
                    n_reg <= 16'h0000;
                end else begin
                    if (seq_start[s])
                        start_reg <= 1'b1;
                    case (st_reg)
                        ST_IDLE: begin
                            if (start_reg) begin
                                start_reg <= seq_start[s];
                                n_reg <= 16'h0000;
                                st_reg <= seq_frame_reg[s] ? ST_FWAIT : ST_ARM;
                            end
                        end
                        ST_ARM: if (r) st_reg <= ST_RUN;
                        ST_RUN: begin
                            if (f) begin
                                n_reg <= last ? 16'h0000 : n_reg + 16'h0001;
                                if (last)
                                    st_reg <= seq_frame_reg[s] ? ST_FWAIT : ST_IDLE;
                            end
                        end
                        default: begin
                            if (ftrig) begin
                                n_reg <= 16'h0000;
                                st_reg <= ST_RUN;
                            end
                        end
                    endcase
                end
            end
        end
    endgenerate

    wire sc0_wr = apb_wr && (PADDR == `ACC_OFF_ASCTRL);
    wire sc1_wr = apb_wr && (PADDR == `ACC_OFF_DSCTRL);
    assign seq_start = {sc1_wr & PWDATA[`ACC_SC_START], sc0_wr & PWDATA[`ACC_SC_START]};
    assign seq_stop = {sc1_wr & PWDATA[`ACC_SC_STOP], sc0_wr & PWDATA[`ACC_SC_STOP]};

    // apb register writes
    always @(posedge MCLK) begin
        if (!RST_N) begin
            mode_reg <= 24'h000000;
            div_reg[0] <= `ACC_RST_DIV;
            div_reg[1] <= `ACC_RST_DIV;
            ft_per_reg <= `ACC_RST_PER;
            ft_csel_reg <= 1'b0;
            ft_lim_reg <= `ACC_RST_LIM;
            gen_en_reg <= 1'b0;
            src_ext_reg <= 1'b0;
            seq_frame_reg <= 2'b00;
            seq_csel_reg <= 2'b00;
            seq_num_reg[0] <= `ACC_RST_NUM;
            seq_num_reg[1] <= `ACC_RST_NUM;
            for (i = 0; i < `ACC_NUM_DDATA; i = i + 1)
                dac_data_reg[i] <= 16'h0000;
            for (i = 0; i < `ACC_NUM_CORR; i = i + 1)
                corr_reg[i] <= 32'h00000000;
        end else if (apb_wr) begin
            if (PADDR == `ACC_OFF_MODE) mode_reg <= PWDATA[23:0];
            else if (PADDR == `ACC_OFF_CLK1) div_reg[0] <= PWDATA[15:0];
            else if (PADDR == `ACC_OFF_CLK2) div_reg[1] <= PWDATA[15:0];
            else if (PADDR == `ACC_OFF_FTCFG) begin
                ft_per_reg <= PWDATA[15:0];
                ft_csel_reg <= PWDATA[`ACC_FT_CSEL];
            end else if (PADDR == `ACC_OFF_FTLIM) ft_lim_reg <= PWDATA[15:0];
            else if (PADDR == `ACC_OFF_GENEN) gen_en_reg <= PWDATA[0];
            else if (PADDR == `ACC_OFF_SRCSEL) src_ext_reg <= PWDATA[0];
            else if (sc0_wr) begin
                seq_frame_reg[0] <= PWDATA[`ACC_SC_FRAME];
                seq_csel_reg[0] <= PWDATA[`ACC_SC_CSEL];
            end else if (sc1_wr) begin
                seq_frame_reg[1] <= PWDATA[`ACC_SC_FRAME];
                seq_csel_reg[1] <= PWDATA[`ACC_SC_CSEL];
            end else if (PADDR == `ACC_OFF_ASNUM) seq_num_reg[0] <= PWDATA[15:0];
            else if (PADDR == `ACC_OFF_DSNUM) seq_num_reg[1] <= PWDATA[15:0];
            else if (dd_wr) dac_data_reg[dd_idx] <= PWDATA[15:0];
            else if (PADDR >= `ACC_BASE_CORR && PADDR < `ACC_BASE_CORR + 12'h060)
                corr_reg[PADDR[6:2] + {PADDR[7], 3'b000}] <= PWDATA;
        end
    end

    // read decode
    always @* begin
        rd_data = 32'h00000000;
        rd_err = 1'b0;
        if (PADDR[1:0] != 2'b00) rd_err = 1'b1;
        else if (PADDR == `ACC_OFF_MODE) rd_data = {8'h00, mode_reg};
        else if (PADDR == `ACC_OFF_GCTRL) rd_data = 32'h00000000;
        else if (PADDR == `ACC_OFF_STAT)
            rd_data = {16'h0000, 4'h0, g_seq[1].st_reg, g_seq[0].st_reg,
                6'h00, busy_reg};
        else if (PADDR == `ACC_OFF_CLK1) rd_data = {16'h0000, div_reg[0]};
        else if (PADDR == `ACC_OFF_CLK2) rd_data = {16'h0000, div_reg[1]};
        else if (PADDR == `ACC_OFF_FTCFG) rd_data = {15'h0000, ft_csel_reg, ft_per_reg};
        else if (PADDR == `ACC_OFF_FTLIM) rd_data = {16'h0000, ft_lim_reg};
        else if (PADDR == `ACC_OFF_GENEN) rd_data = {31'h00000000, gen_en_reg};
        else if (PADDR == `ACC_OFF_SRCSEL) rd_data = {31'h00000000, src_ext_reg};
        else if (PADDR == `ACC_OFF_ASCTRL)
            rd_data = {28'h0000000, 1'b0, seq_csel_reg[0], seq_frame_reg[0], 1'b0};
        else if (PADDR == `ACC_OFF_DSCTRL)
            rd_data = {28'h0000000, 1'b0, seq_csel_reg[1], seq_frame_reg[1], 1'b0};
        else if (PADDR == `ACC_OFF_ASNUM) rd_data = {16'h0000, seq_num_reg[0]};
        else if (PADDR == `ACC_OFF_DSNUM) rd_data = {16'h0000, seq_num_reg[1]};
        else if (PADDR[11:5] == `ACC_BASE_DDATA >> 5) rd_data = {16'h0000, dac_data_reg[dd_idx]};
        else if (PADDR[11:6] == `ACC_BASE_ADATA >> 6)
            rd_data = {16'h0000, adc_data_reg[PADDR[5:2]]};
        else if (PADDR >= `ACC_BASE_CORR && PADDR < `ACC_BASE_CORR + 12'h060)
            rd_data = corr_reg[PADDR[6:2] + {PADDR[7], 3'b000}];
        else rd_err = 1'b1;
    end

    // apb answer one cycle into the access phase
    always @(posedge MCLK) begin
        if (!RST_N) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= PSEL & PENABLE & ~PREADY;
            PSLVERR <= PSEL & PENABLE & ~PREADY & rd_err;
            if (PSEL && PENABLE && !PREADY)
                PRDATA <= (PWRITE || rd_err) ? 32'h00000000 : rd_data;
        end
    end

    // adc conversion start and result capture
    wire [4:0] a_ci = {1'b0, ADC_RES_CH};
    wire [15:0] a_cor = adc_cor[ADC_RES_CH[3]] ?
        corr_fn(ADC_RES_DATA, corr_reg[a_ci], 1'b1) : ADC_RES_DATA;
    always @(posedge MCLK) begin
        if (!RST_N) begin
            ADC_CONVST <= 2'b00;
            SEQ_ADC_VALID <= 1'b0;
            SEQ_ADC_DATA <= 16'h0000;
            for (j = 0; j < `ACC_NUM_ADATA; j = j + 1)
                adc_data_reg[j] <= 16'h0000;
        end else begin
            ADC_CONVST <= (adc_req & ~adc_seq) | (seq_ev[0] ? adc_seq : 2'b00);
            SEQ_ADC_VALID <= ADC_RES_VALID & adc_seq[ADC_RES_CH[3]];
            if (ADC_RES_VALID) begin
                adc_data_reg[ADC_RES_CH] <= a_cor;
                SEQ_ADC_DATA <= a_cor;
            end
        end
    end

    // dac transfer requests
    always @* begin
        pend_set = 8'h00;
        load_set = 2'b00;
        pick = 3'd0;
        for (m = 0; m < 2; m = m + 1) begin
            if ((dac_req[m] && dac_ctl[m] && !dac_seq[m]) || (seq_ev[1] && dac_seq[m])) begin
                pend_set[m*4 +: 4] = 4'hf;
                load_set[m] = 1'b1;
            end
        end
        if (dd_wr && !dac_ctl[dd_idx[2]] && !dac_seq[dd_idx[2]]) begin
            pend_set[dd_idx] = 1'b1;
            load_set[dd_idx[2]] = 1'b1;
        end
        for (m = 7; m >= 0; m = m - 1)
            if (pend_reg[m])
                pick = m[2:0];
        pend_next = pend_reg;
        if (pend_reg != 8'h00)
            pend_next[pick] = 1'b0;
        pend_next = pend_next | pend_set;
    end

    // dac transfer engine: channel words first, then common load
    wire [4:0] d_ci = {2'b00, pick} + 5'd16;
    wire [15:0] d_raw = dac_data_reg[pick];
    always @(posedge MCLK) begin
        if (!RST_N) begin
            pend_reg <= 8'h00;
            load_reg <= 2'b00;
            busy_reg <= 2'b00;
            DAC_WR <= 1'b0;
            DAC_ADDR <= 3'd0;
            DAC_DATA <= 16'h0000;
            DAC_LOAD <= 2'b00;
            SEQ_DAC_PULL <= 1'b0;
        end else begin
            pend_reg <= pend_next;
            SEQ_DAC_PULL <= seq_ev[1];
            DAC_WR <= (pend_reg != 8'h00);
            DAC_LOAD <= 2'b00;
            // load set wins over the done clear
            busy_reg <= (busy_reg & ~DAC_DONE) | load_set;
            if (pend_reg != 8'h00) begin
                DAC_ADDR <= pick;
                DAC_DATA <= dac_cor[pick[2]] ?
                    corr_fn(d_raw, corr_reg[d_ci], dac_bip[pick[2]]) : d_raw;
                load_reg <= load_reg | load_set;
            end else begin
                DAC_LOAD <= load_reg;
                load_reg <= load_set;
            end
        end
    end
endmodule

// [acc_consts.vh]
// register offsets, field positions, reset values and counts for the converter control
// assumes byte addressing on a 32-bit apb bus, one aligned word per register
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH
`define ACC_OFF_MODE 12'h000
`define ACC_OFF_GCTRL 12'h004
`define ACC_OFF_STAT 12'h008
`define ACC_OFF_CLK1 12'h00c
`define ACC_OFF_CLK2 12'h010
`define ACC_OFF_FTCFG 12'h014
`define ACC_OFF_FTLIM 12'h018
`define ACC_OFF_GENEN 12'h01c
`define ACC_OFF_SRCSEL 12'h020
`define ACC_OFF_ASCTRL 12'h024
`define ACC_OFF_ASNUM 12'h028
`define ACC_OFF_DSCTRL 12'h02c
`define ACC_OFF_DSNUM 12'h030
`define ACC_BASE_DDATA 12'h040
`define ACC_BASE_ADATA 12'h080
`define ACC_BASE_CORR 12'h100
`define ACC_NUM_DDATA 8
`define ACC_NUM_ADATA 16
`define ACC_NUM_CORR 24
`define ACC_CORR_DAC0 24'd16
// mode register fields
`define ACC_MODE_ASEQ 0
`define ACC_MODE_DSEQ 4
`define ACC_MODE_DCTL 8
`define ACC_MODE_DBIP 12
`define ACC_MODE_ACOR 16
`define ACC_MODE_DCOR 20
// global control fields
`define ACC_GC_AREQ 0
`define ACC_GC_DREQ 4
// sequencer control fields, then the frame trigger clock select
`define ACC_SC_START 0
`define ACC_SC_FRAME 1
`define ACC_SC_CSEL 2
`define ACC_SC_STOP 3
`define ACC_FT_CSEL 16
// reset values
`define ACC_RST_DIV 16'h0000
`define ACC_RST_PER 16'h0001
`define ACC_RST_LIM 16'h0000
`define ACC_RST_NUM 16'h0000
// correction scale: gain over 2^18, offset over 2^2
`define ACC_GAIN_SHIFT 18
`define ACC_OFF_SHIFT 2
`define ACC_POS_FS 16'h7fff
`define ACC_NEG_FS 16'h8000
`define ACC_UNI_TOP 16'hffff
`define ACC_UNI_ZERO 16'h0000
`endif

// [acc_ctrl_properties.sv]
// port checker for the converter control block
// bound to acc_ctrl, sees its ports only
`timescale 1ns/100ps
module acc_ctrl_chk (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // converters
    input wire logic [1:0] ADC_CONVST,
    input wire logic ADC_RES_VALID,
    input wire logic SEQ_ADC_VALID,
    input wire logic DAC_WR,
    input wire logic [2:0] DAC_ADDR,
    input wire logic [1:0] DAC_LOAD
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RST_N);
    property p_rdy_wait;
        PSEL && $rose(PENABLE) |=> PREADY;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait)
        else $error("ready late");
    property p_rdy_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready too long");
    property p_err_rdy;
        PSLVERR |-> PREADY && $past(PSEL && PENABLE);
    endproperty
    a_err_rdy: assert property (p_err_rdy)
        else $error("stray error");
    property p_conv_pulse;
        ADC_CONVST != 2'b00 |=> ADC_CONVST == 2'b00;
    endproperty
    a_conv_pulse: assert property (p_conv_pulse)
        else $error("convert start too long");
    property p_seq_cause;
        SEQ_ADC_VALID |-> $past(ADC_RES_VALID) || $past(ADC_RES_VALID, 2);
    endproperty
    a_seq_cause: assert property (p_seq_cause)
        else $error("sequencer data without result");
    property p_dac_asc;
        DAC_WR && $past(DAC_WR) |-> DAC_ADDR > $past(DAC_ADDR);
    endproperty
    a_dac_asc: assert property (p_dac_asc)
        else $error("dac words out of order");
    property p_load_follows;
        $fell(DAC_WR) |-> DAC_LOAD != 2'b00;
    endproperty
    a_load_follows: assert property (p_load_follows)
        else $error("no load after words");
    property p_load_alone;
        DAC_LOAD != 2'b00 |-> !DAC_WR && $past(DAC_WR);
    endproperty
    a_load_alone: assert property (p_load_alone)
        else $error("load without words");
    c_err: cover property (PSLVERR);
    c_both: cover property (DAC_LOAD == 2'b11);
    c_seq: cover property (SEQ_ADC_VALID);
endmodule

bind acc_ctrl acc_ctrl_chk u_chk (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .ADC_CONVST(ADC_CONVST),
    .ADC_RES_VALID(ADC_RES_VALID), .SEQ_ADC_VALID(SEQ_ADC_VALID), .DAC_WR(DAC_WR),
    .DAC_ADDR(DAC_ADDR), .DAC_LOAD(DAC_LOAD));

// [acc_conv_model.sv]
// converter chip model: adc returning a fixed pattern, dac done pulses
// assumes pins synchronous to the controller clock
`timescale 1ns/100ps
module acc_conv_model (
    // clock and pace
    input wire logic clk,
    input wire logic slow,
    // adc side
    input wire logic [1:0] convst,
    output logic res_valid = 1'b0,
    output logic [3:0] res_ch = 4'h0,
    output logic [15:0] res_data = 16'h0,
    // dac side
    input wire logic [1:0] load,
    output logic [1:0] done = 2'b00
);
    logic [3:0] cnt = 4'h0;
    logic act = 1'b0;
    logic idx = 1'b0;
    int dly[2] = '{0, 0};
    // two's complement sample pattern
    function automatic logic [15:0] pat(input logic [2:0] k);
        case (k)
            3'h0: pat = 16'h4000;
            3'h1: pat = 16'h7fff;
            3'h2: pat = 16'h8000;
            3'h3: pat = 16'hffff;
            default: pat = {13'h0a5a, k};
        endcase
    endfunction
    // eight results per start, idle lines keep changing
    always @(posedge clk) begin
        res_valid <= 1'b0;
        res_ch <= ~res_ch;
        res_data <= ~res_data;
        if (convst != 2'b00) begin
            act <= 1'b1;
            idx <= convst[1];
            cnt <= 4'h0;
        end else if (act) begin
            cnt <= cnt + 4'h1;
            if (cnt >= 4'h2) begin
                res_valid <= 1'b1;
                res_ch <= {idx, cnt[2:0] - 3'h2};
                res_data <= pat(cnt[2:0] - 3'h2);
            end
            if (cnt == 4'h9) begin
                act <= 1'b0;
            end
        end
    end
    // analog update takes short or long time
    always @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            done[i] <= dly[i] == 1;
            if (load[i]) begin
                dly[i] <= slow ? 40 : 2;
            end else if (dly[i] > 0) begin
                dly[i] <= dly[i] - 1;
            end
        end
    end
endmodule

// [acc_tb.sv]
// self-checking bench for the converter control block
// assumes the design, its checker and the converter model
`timescale 1ns/100ps
`include "acc_consts.vh"
module testbench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, rv, dwr, sav, spull;
    logic [1:0] convst, dload, ddone;
    logic [3:0] rch;
    logic [2:0] daddr;
    logic [15:0] rdat, ddat, sad;
    logic [18:0] wq[$];
    logic [1:0] lq[$];
    logic [15:0] sq[$];
    int n_conv, n_pull, n_sv;
    int num_errors = 0, n_compared = 0;
    logic [31:0] dm[7] = '{32'h0, 32'h100000, 32'h100000, 32'h101000, 32'h101000,
        32'h101000, 32'h100000};
    logic [31:0] dc[7] = '{32'h0, 32'hfffc, 32'h4, 32'hfffc, 32'h4, 32'h20000008,
        32'h20000000};
    logic [15:0] di[7] = '{16'hffff, 16'hffff, 16'h0, 16'h7fff, 16'h8000, 16'h4000,
        16'h8000};
    logic [15:0] dx[7] = '{16'hffff, 16'hffff, 16'h0, 16'h7fff, 16'h8000, 16'h3dfe,
        16'h7c00};
    logic [15:0] ae[8] = '{16'h4000, 16'h7fff, 16'h8000, 16'hffff, 16'h3dfe, 16'h7fff,
        16'h8000, 16'h0000};
    logic [31:0] ac[4] = '{32'h20000008, 32'h80000000, 32'h00000004, 32'h0000fffc};
    acc_ctrl u_dut (
        .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .ADC_CONVST(convst), .ADC_RES_VALID(rv),
        .ADC_RES_CH(rch), .ADC_RES_DATA(rdat), .DAC_WR(dwr), .DAC_ADDR(daddr),
        .DAC_DATA(ddat), .DAC_LOAD(dload), .DAC_DONE(ddone), .SEQ_ADC_VALID(sav),
        .SEQ_ADC_DATA(sad), .SEQ_DAC_PULL(spull), .EXT_CCLK(2'b00), .EXT_FTRIG(1'b0));
    acc_conv_model u_conv (.clk(mclk), .slow(slow), .convst(convst), .res_valid(rv),
        .res_ch(rch), .res_data(rdat), .load(dload), .done(ddone));
    always #12.5 mclk = ~mclk;
    // port monitor
    always @(posedge mclk) begin
        if (rst_n) begin
            if (dwr === 1'b1) wq.push_back({daddr, ddat});
            if (dload !== 2'b00) lq.push_back(dload);
            if (sav === 1'b1) sq.push_back(sad);
            n_conv += (convst[0] === 1'b1);
            n_pull += (spull === 1'b1);
            n_sv += (sav === 1'b1);
        end
    end
    task automatic clr;
        wq.delete();
        lq.delete();
        sq.delete();
        n_conv = 0;
        n_pull = 0;
        n_sv = 0;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        n_compared++;
        if (g !== x) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 16) num_errors++;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic ex);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk($sformatf("reg %h", a), {x[30:0], ex}, {q[30:0], e});
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        rd(`ACC_OFF_MODE, 32'h0, 1'b0);
        rd(`ACC_OFF_FTCFG, 32'h1, 1'b0);
        rd(12'h0c0, 32'h0, 1'b1);
        rd(12'h002, 32'h0, 1'b1);
        for (int i = 0; i < 7; i++) begin
            wr(`ACC_OFF_MODE, dm[i]);
            wr(`ACC_BASE_CORR + 12'h040, dc[i]);
            clr();
            wr(`ACC_BASE_DDATA, {16'h0, di[i]});
            repeat (8) @(posedge mclk);
            chk("dac update", {5'h0, 4'd1, 2'd1, 2'b01, 3'h0, dx[i]},
                {5'h0, 4'(wq.size()), 2'(lq.size()), lq[0], wq[0]});
        end
        slow <= 1'b1;
        wr(`ACC_BASE_DDATA, 32'h1234);
        rd(`ACC_OFF_STAT, 32'h1, 1'b0);
        repeat (60) @(posedge mclk);
        rd(`ACC_OFF_STAT, 32'h0, 1'b0);
        wr(`ACC_OFF_MODE, 32'h300);
        clr();
        for (int i = 0; i < 8; i++) wr(`ACC_BASE_DDATA + 12'(4 * i), 32'h1110 * i);
        repeat (4) @(posedge mclk);
        chk("early update", 0, wq.size() + lq.size());
        wr(`ACC_OFF_GCTRL, 32'h30);
        rd(`ACC_OFF_STAT, 32'h3, 1'b0);
        repeat (12) @(posedge mclk);
        for (int i = 0; i < 8; i++)
            chk("ctl word", {13'h0, 3'(i), 16'(32'h1110 * i)}, {13'h0, wq[i]});
        chk("ctl load", {1'b1, 29'h0, 2'b11}, {lq.size() == 1, 29'h0, lq[0]});
        repeat (50) @(posedge mclk);
        wr(`ACC_OFF_MODE, 32'h0);
        clr();
        repeat (20) @(posedge mclk);
        chk("idle conv", 0, n_conv);
        for (int p = 0; p < 2; p++) begin
            wr(`ACC_OFF_GCTRL, 32'h1);
            repeat (20) @(posedge mclk);
            for (int i = 0; i < 4; i++)
                rd(`ACC_BASE_ADATA + 12'(4 * i), {16'h0, ae[4 * p + i]}, 1'b0);
            wr(`ACC_OFF_MODE, 32'h10000);
            for (int i = 0; i < 4; i++) wr(`ACC_BASE_CORR + 12'(4 * i), ac[i]);
        end
        chk("manual conv", 2, n_conv);
        wr(`ACC_OFF_MODE, 32'h11);
        wr(`ACC_OFF_CLK1, 32'h8);
        wr(`ACC_OFF_ASNUM, 32'h3);
        wr(`ACC_OFF_DSNUM, 32'h3);
        clr();
        wr(`ACC_OFF_ASCTRL, 32'h1);
        wr(`ACC_OFF_DSCTRL, 32'h1);
        repeat (40) @(posedge mclk);
        chk("gated", 0, n_conv + n_pull);
        wr(`ACC_OFF_GENEN, 32'h1);
        repeat (150) @(posedge mclk);
        chk("seq run", {8'h0, 8'd3, 8'd3, 8'd24}, {8'h0, 8'(n_conv), 8'(n_pull), 8'(n_sv)});
        chk("seq data", {ae[0], ae[1]}, {sq[0], sq[1]});
        wr(`ACC_OFF_ASNUM, 32'h0);
        wr(`ACC_OFF_ASCTRL, 32'h1);
        clr();
        repeat (200) @(posedge mclk);
        wr(`ACC_OFF_ASCTRL, 32'h8);
        chk("endless", 1, n_conv > 6);
        wr(`ACC_OFF_GENEN, 32'h0);
        wr(`ACC_OFF_FTCFG, 32'h4);
        wr(`ACC_OFF_FTLIM, 32'h2);
        wr(`ACC_OFF_ASNUM, 32'h2);
        wr(`ACC_OFF_ASCTRL, 32'h3);
        clr();
        wr(`ACC_OFF_GENEN, 32'h1);
        repeat (600) @(posedge mclk);
        chk("frames", 4, n_conv);
        tally_and_finish();
    end
endmodule
